//--- logic/rcf_consts.svh
// Contract
// - each active stage compares measured slope against its pick-up every processing step
// - three selectable frequency references, each refreshed on a 5 ms time base
// - slope above global maximum rate (default 20 Hz/s) blocks the whole function
// - each stage has a static enable, default off; disabled gives no indication
// - forced status normal/start/trip/blocked honoured only while forcing is permitted; a forced normal is ignored and normal evaluation runs
// - per-stage pick-up in 0.01 Hz/s steps, default 0.2 Hz/s
// - started stage resets only below pick-up minus 100 mHz/s hysteresis
// - rising mode acts on increasing, falling on decreasing frequency; rising default
// - both mode acts when slope magnitude in either direction exceeds pick-up
// - frequency limit selector not used (default) or used; unused ignores limits
// - limits used, falling or both: trip only below under-frequency limit (49.95)
// - limits used, rising or both: trip only above over-frequency limit (51)
// - pick-up, mode and limits held per setting group, switchable while running
// - stage takes part only in groups where its use flag is set
// - max rate, enables and forced status are static, not per group
// - trip only after definite delay elapsed continuously; timer cleared when start resets
// - stage enables act only once the frequency protection group is activated
// - block input sampled each step; block at pick-up reports blocked, no processing
// - block after start withdraws start and resets timing as if pick-up ended
// - resettable counts of start, trip, blocked and on/off events for each
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

`define RCF_CLK_PERIOD_NS 100
`define RCF_TIME_BASE_NS  5000000
`define RCF_NS_PER_S      1000000000
`define RCF_STEP_CYCLES   (`RCF_TIME_BASE_NS / `RCF_CLK_PERIOD_NS)
`define RCF_SAMPLES_PER_S (`RCF_NS_PER_S / `RCF_TIME_BASE_NS)
`define RCF_SLOPE_W       26
`define RCF_FREQ_W        16
`define RCF_CNT_W         16
// settings in hundredths: Hz/s for rates, Hz for frequencies
`define RCF_HYST          16'h000A
`define RCF_MAX_RATE_DEF  16'h07D0
`define RCF_PICKUP_DEF    16'h0014
`define RCF_F_UNDER_DEF   16'h1383
`define RCF_F_OVER_DEF    16'h13EC

`endif

//--- logic/rcf_pkg.sv
`default_nettype none
`include "rcf_consts.svh"
package rcf_pkg;

  typedef logic signed [`RCF_SLOPE_W-1:0] rcf_slope_t;
  typedef logic        [`RCF_FREQ_W-1:0]  rcf_freq_t;

  typedef enum logic [3:0] {
    RCF_ST_NORMAL  = 4'h1,
    RCF_ST_START   = 4'h2,
    RCF_ST_TRIP    = 4'h4,
    RCF_ST_BLOCKED = 4'h8
  } rcf_status_t;

  typedef enum logic [2:0] {
    RCF_MODE_RISING  = 3'h1,
    RCF_MODE_FALLING = 3'h2,
    RCF_MODE_BOTH    = 3'h4
  } rcf_mode_t;

  typedef struct packed {
    logic        used;
    rcf_mode_t   mode;
    logic        limit_en;
    logic [15:0] pickup;
    rcf_freq_t   f_under;
    rcf_freq_t   f_over;
    logic [15:0] delay_steps;
  } rcf_grp_set_t;

  typedef struct packed {
    logic start_on;
    logic start_off;
    logic trip_on;
    logic trip_off;
    logic blk_on;
    logic blk_off;
  } rcf_events_t;

  typedef struct packed {
    logic [`RCF_CNT_W-1:0] start_cnt;
    logic [`RCF_CNT_W-1:0] trip_cnt;
    logic [`RCF_CNT_W-1:0] blk_cnt;
  } rcf_counts_t;

  typedef struct packed {
    rcf_status_t status;
    logic [15:0] timer;
  } rcf_stage_state_t;

endpackage : rcf_pkg
`default_nettype wire

//--- logic/rcf_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"
module rcf_stage (
  // clock and reset
  input  wire  logic                     clk,
  input  wire  logic                     rst,
  // processing step and measurement
  input  wire  logic                     step,
  input  wire  rcf_pkg::rcf_slope_t      slope,
  input  wire  rcf_pkg::rcf_freq_t       freq,
  // control
  input  wire  logic                     enable,
  input  wire  logic                     force_en,
  input  wire  rcf_pkg::rcf_status_t     force_status,
  input  wire  logic                     block,
  input  wire  rcf_pkg::rcf_grp_set_t    set,
  // result
  output logic [15:0]                    timer,
  output rcf_pkg::rcf_status_t           status
);
  import rcf_pkg::*;

  rcf_stage_state_t                s_reg;
  rcf_stage_state_t                s_next;
  logic [`RCF_SLOPE_W-1:0]         up_mag;
  logic [`RCF_SLOPE_W-1:0]         dn_mag;
  logic [`RCF_SLOPE_W-1:0]         mag;
  logic [15:0]                     thr;
  logic                            held;
  logic                            picked;
  logic                            permit;
  logic [15:0]                     timer_inc;

  always_comb begin
    s_next = s_reg;
    up_mag = slope[`RCF_SLOPE_W-1] ? '0 : slope;
    dn_mag = slope[`RCF_SLOPE_W-1] ? `RCF_SLOPE_W'(-slope) : '0;
    case (set.mode)
      RCF_MODE_RISING:  mag = up_mag;
      RCF_MODE_FALLING: mag = dn_mag;
      RCF_MODE_BOTH:    mag = up_mag | dn_mag;
      default:          mag = '0;
    endcase
    held = (s_reg.status == RCF_ST_START) || (s_reg.status == RCF_ST_TRIP);
    // keep threshold from wrapping when pick-up is below the hysteresis
    thr = (held && set.pickup > `RCF_HYST) ? set.pickup - `RCF_HYST :
          (held ? 16'h0000 : set.pickup);
    picked = mag > {{(`RCF_SLOPE_W-16){1'b0}}, thr};
    case (set.mode)
      RCF_MODE_RISING:  permit = freq > set.f_over;
      RCF_MODE_FALLING: permit = freq < set.f_under;
      RCF_MODE_BOTH:    permit = (freq > set.f_over) || (freq < set.f_under);
      default:          permit = 1'b0;
    endcase
    permit = permit || !set.limit_en;
    timer_inc = (s_reg.timer == 16'hFFFF) ? s_reg.timer : s_reg.timer + 16'h0001;
    if (!enable) begin
      s_next.status = RCF_ST_NORMAL;
      s_next.timer  = 16'h0000;
    end else if (step) begin
      if (force_en && force_status != RCF_ST_NORMAL) begin
        s_next.status = force_status;
        s_next.timer  = 16'h0000;
      end else if (!picked) begin
        s_next.status = RCF_ST_NORMAL;
        s_next.timer  = 16'h0000;
      end else if (block) begin
        s_next.status = RCF_ST_BLOCKED;
        s_next.timer  = 16'h0000;
      end else begin
        s_next.timer  = timer_inc;
        // permit gates only the trip; start still shows the approaching fault
        s_next.status = (timer_inc >= set.delay_steps && permit) ? RCF_ST_TRIP :
                        RCF_ST_START;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.status <= RCF_ST_NORMAL;
      s_reg.timer  <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.status;
  assign timer  = s_reg.timer;

endmodule : rcf_stage
`default_nettype wire

//--- logic/rcf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"
module rcf_top #(
  parameter int N_STAGES    = 8,
  parameter int N_GROUPS    = 8,
  parameter int STEP_CYCLES = `RCF_STEP_CYCLES
) (
  // clock and reset
  input  wire  logic                                          clk,
  input  wire  logic                                          rst,
  // frequency references from the tracking front end
  input  wire  rcf_pkg::rcf_freq_t [2:0]                      freq_ref,
  input  wire  logic [2:0]                                    freq_ok,
  input  wire  logic [1:0]                                    ref_sel,
  // static settings
  input  wire  logic                                          func_active,
  input  wire  logic [15:0]                                   max_rate,
  input  wire  logic [N_STAGES-1:0]                           stage_en,
  input  wire  logic                                          force_allow,
  input  wire  rcf_pkg::rcf_status_t [N_STAGES-1:0]           force_status,
  // setting groups
  input  wire  logic [$clog2(N_GROUPS)-1:0]                   active_group,
  input  wire  rcf_pkg::rcf_grp_set_t [N_GROUPS-1:0][N_STAGES-1:0] grp_set,
  // blocking matrix and counter reset
  input  wire  logic [N_STAGES-1:0]                           block_in,
  input  wire  logic                                          cnt_clr,
  // per-stage results
  output rcf_pkg::rcf_status_t [N_STAGES-1:0]                 stage_status,
  output rcf_pkg::rcf_events_t [N_STAGES-1:0]                 stage_events,
  output rcf_pkg::rcf_counts_t [N_STAGES-1:0]                 stage_counts,
  output logic [N_STAGES-1:0][15:0]                           time_left,
  // function-wide results
  output rcf_pkg::rcf_slope_t                                 slope_out,
  output rcf_pkg::rcf_freq_t                                  freq_out,
  output logic                                                max_blocked,
  output logic                                                step_out
);
  import rcf_pkg::*;

  localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);
  localparam logic [`RCF_SLOPE_W-1:0] SPS = `RCF_SLOPE_W'(`RCF_SAMPLES_PER_S);

  typedef struct packed {
    logic [31:0]                     tick_cnt;
    logic                            step;
    rcf_freq_t                       f_prev;
    logic                            prev_ok;
    rcf_freq_t                       f_now;
    rcf_slope_t                      slope;
    logic                            max_blk;
    logic [N_STAGES-1:0]             blk_smp;
    rcf_status_t [N_STAGES-1:0]      status_q;
    rcf_events_t [N_STAGES-1:0]      evt;
    rcf_counts_t [N_STAGES-1:0]      cnt;
    logic [N_STAGES-1:0][15:0]       left;
  } rcf_top_state_t;

  rcf_top_state_t                    s_reg;
  rcf_top_state_t                    s_next;

  // selected reference and slope arithmetic
  rcf_freq_t                         f_sel;
  logic                              f_sel_ok;
  logic signed [`RCF_SLOPE_W-1:0]    diff;
  logic signed [`RCF_SLOPE_W-1:0]    slope_calc;
  logic [`RCF_SLOPE_W-1:0]           slope_abs;
  logic                              tick;

  // per-stage wiring to and from the stage instances
  rcf_grp_set_t [N_STAGES-1:0]       cur_set;
  logic [N_STAGES-1:0]               eff_en;
  logic [N_STAGES-1:0]               eff_blk;
  rcf_status_t [N_STAGES-1:0]        st_now;
  logic [N_STAGES-1:0][15:0]         st_timer;

  // reference selection: an unused code falls back to the primary
  always_comb begin
    case (ref_sel)
      2'h1:    begin
        f_sel    = freq_ref[1];
        f_sel_ok = freq_ok[1];
      end
      2'h2:    begin
        f_sel    = freq_ref[2];
        f_sel_ok = freq_ok[2];
      end
      default: begin
        f_sel    = freq_ref[0];
        f_sel_ok = freq_ok[0];
      end
    endcase
  end

  // slope in hundredths of Hz/s: sample difference times samples per second
  always_comb begin
    diff       = $signed({{(`RCF_SLOPE_W-`RCF_FREQ_W){1'b0}}, f_sel})
               - $signed({{(`RCF_SLOPE_W-`RCF_FREQ_W){1'b0}}, s_reg.f_prev});
    slope_calc = `RCF_SLOPE_W'(diff * $signed(SPS));
    slope_abs  = slope_calc[`RCF_SLOPE_W-1] ? `RCF_SLOPE_W'(-slope_calc) : slope_calc;
  end

  assign tick = (s_reg.tick_cnt == STEP_LAST);

  // group-dependent settings and effective enables
  genvar g;
  generate
    for (g = 0; g < N_STAGES; g++) begin : g_stage
      always_comb begin
        cur_set[g] = grp_set[active_group][g];
        // stage enable only matters once the whole function is active
        eff_en[g]  = func_active && stage_en[g] && cur_set[g].used;
        eff_blk[g] = s_reg.blk_smp[g] || s_reg.max_blk;
      end

      rcf_stage u_stage (
        .clk          (clk),
        .rst          (rst),
        .step         (s_reg.step),
        .slope        (s_reg.slope),
        .freq         (s_reg.f_now),
        .enable       (eff_en[g]),
        .force_en     (force_allow),
        .force_status (force_status[g]),
        .block        (eff_blk[g]),
        .set          (cur_set[g]),
        .timer        (st_timer[g]),
        .status       (st_now[g])
      );
    end
  endgenerate

  always_comb begin
    s_next      = s_reg;
    s_next.step = 1'b0;

    // fixed processing time base
    s_next.tick_cnt = tick ? 32'h0000_0000 : s_reg.tick_cnt + 32'h0000_0001;

    if (tick) begin
      s_next.step    = 1'b1;
      // the block input is sampled once, at the start of the step
      s_next.blk_smp = block_in;
      if (f_sel_ok) begin
        s_next.f_now   = f_sel;
        s_next.f_prev  = f_sel;
        s_next.prev_ok = 1'b1;
        // no slope until two good samples in a row exist
        s_next.slope   = s_reg.prev_ok ? slope_calc : '0;
        s_next.max_blk = s_reg.prev_ok &&
                         (slope_abs > {{(`RCF_SLOPE_W-16){1'b0}}, max_rate});
      end else begin
        // a lost reference restarts the difference chain rather than
        // producing a huge false slope when it comes back
        s_next.prev_ok = 1'b0;
        s_next.slope   = '0;
        s_next.max_blk = 1'b0;
      end
    end

    for (int i = 0; i < N_STAGES; i++) begin
      s_next.status_q[i] = st_now[i];
      s_next.evt[i].start_on  = (st_now[i] == RCF_ST_START) &&
                                (s_reg.status_q[i] != RCF_ST_START);
      s_next.evt[i].start_off = (st_now[i] != RCF_ST_START) &&
                                (s_reg.status_q[i] == RCF_ST_START);
      s_next.evt[i].trip_on   = (st_now[i] == RCF_ST_TRIP) &&
                                (s_reg.status_q[i] != RCF_ST_TRIP);
      s_next.evt[i].trip_off  = (st_now[i] != RCF_ST_TRIP) &&
                                (s_reg.status_q[i] == RCF_ST_TRIP);
      s_next.evt[i].blk_on    = (st_now[i] == RCF_ST_BLOCKED) &&
                                (s_reg.status_q[i] != RCF_ST_BLOCKED);
      s_next.evt[i].blk_off   = (st_now[i] != RCF_ST_BLOCKED) &&
                                (s_reg.status_q[i] == RCF_ST_BLOCKED);

      // clear first, so an event in the clear cycle still counts once
      if (cnt_clr) begin
        s_next.cnt[i] = '0;
      end
      if (s_next.evt[i].start_on) begin
        s_next.cnt[i].start_cnt = (cnt_clr ? '0 : s_reg.cnt[i].start_cnt)
                                  + `RCF_CNT_W'(1);
      end
      if (s_next.evt[i].trip_on) begin
        s_next.cnt[i].trip_cnt = (cnt_clr ? '0 : s_reg.cnt[i].trip_cnt)
                                 + `RCF_CNT_W'(1);
      end
      if (s_next.evt[i].blk_on) begin
        s_next.cnt[i].blk_cnt = (cnt_clr ? '0 : s_reg.cnt[i].blk_cnt)
                                + `RCF_CNT_W'(1);
      end

      // steps left to trip while started; zero otherwise
      if (st_now[i] == RCF_ST_START && cur_set[i].delay_steps > st_timer[i]) begin
        s_next.left[i] = cur_set[i].delay_steps - st_timer[i];
      end else begin
        s_next.left[i] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.tick_cnt <= 32'h0000_0000;
      s_reg.step     <= 1'b0;
      s_reg.f_prev   <= '0;
      s_reg.prev_ok  <= 1'b0;
      s_reg.f_now    <= '0;
      s_reg.slope    <= '0;
      s_reg.max_blk  <= 1'b0;
      s_reg.blk_smp  <= '0;
      for (int i = 0; i < N_STAGES; i++) begin
        s_reg.status_q[i] <= RCF_ST_NORMAL;
      end
      s_reg.evt      <= '0;
      s_reg.cnt      <= '0;
      s_reg.left     <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stage_status = s_reg.status_q;
  assign stage_events = s_reg.evt;
  assign stage_counts = s_reg.cnt;
  assign time_left    = s_reg.left;
  assign slope_out    = s_reg.slope;
  assign freq_out     = s_reg.f_now;
  assign max_blocked  = s_reg.max_blk;
  assign step_out     = s_reg.step;

endmodule : rcf_top
`default_nettype wire

//--- verif/rcf_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_top_properties #(
  parameter int N_STAGES    = 8,
  parameter int STEP_CYCLES = 50000
) (
  // clock and reset
  input wire logic                                 clk,
  input wire logic                                 rst,
  // settings
  input wire logic                                 func_active,
  input wire logic [15:0]                          max_rate,
  input wire logic                                 cnt_clr,
  // results
  input wire rcf_pkg::rcf_status_t [N_STAGES-1:0]  stage_status,
  input wire rcf_pkg::rcf_events_t [N_STAGES-1:0]  stage_events,
  input wire rcf_pkg::rcf_counts_t [N_STAGES-1:0]  stage_counts,
  input wire logic [N_STAGES-1:0][15:0]            time_left,
  input wire rcf_pkg::rcf_slope_t                  slope_out,
  input wire logic                                 max_blocked,
  input wire logic                                 step_out
);
  import rcf_pkg::*;
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  logic        seen_reg;
  rcf_slope_t  mag;
  logic        all_normal;

  // the first pulse is skipped: its distance from reset is counted differently
  always_comb gap_next = step_out ? 16'h0 : gap_reg + 16'h1;
  always_comb mag = slope_out[$bits(rcf_slope_t)-1] ? -slope_out : slope_out;
  always_comb all_normal = (stage_status == {N_STAGES{RCF_ST_NORMAL}});
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_reg  <= 16'h0;
      seen_reg <= 1'h0;
    end else begin
      gap_reg  <= gap_next;
      seen_reg <= seen_reg | step_out;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence off_two;
    !func_active ##1 !func_active;
  endsequence

  chk_step_period: assert property (step_out && seen_reg |-> gap_reg == 16'(STEP_CYCLES - 1))
    else $error("step spacing wrong");
  chk_step_pulse: assert property (step_out |=> !step_out)
    else $error("step pulse too long");
  chk_status_onehot: assert property ($onehot(stage_status[0]) && $onehot(stage_status[N_STAGES-1]))
    else $error("status not exclusive");
  chk_status_timing: assert property ($changed(stage_status) && !all_normal |-> $past(step_out, 2))
    else $error("status changed off step");
  chk_max_block: assert property (step_out |-> max_blocked == (mag > rcf_slope_t'(max_rate)))
    else $error("max rate flag wrong");
  chk_slope_hold: assert property ($changed(slope_out) |-> step_out)
    else $error("slope changed off step");
  chk_disabled_normal: assert property (off_two |=> all_normal)
    else $error("inactive function not normal");
  chk_trip_event: assert property (stage_events[0].trip_on |->
      stage_status[0] == RCF_ST_TRIP && $past(stage_status[0]) != RCF_ST_TRIP)
    else $error("trip event without trip entry");
  chk_blk_count: assert property (stage_events[0].blk_on && !$past(cnt_clr) |->
      stage_counts[0].blk_cnt == $past(stage_counts[0].blk_cnt) + 16'h1)
    else $error("blocked count not advanced");
  chk_time_idle: assert property (stage_status[0] != RCF_ST_START |-> time_left[0] == 16'h0)
    else $error("time left outside start");
endmodule : rcf_top_properties
`default_nettype wire

//--- verif/rcf_freq_src.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_freq_src (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // next measurement chosen by the bench
  input  wire rcf_pkg::rcf_freq_t        f_cmd,
  input  wire logic                      ok_cmd,
  // tracking outputs
  output rcf_pkg::rcf_freq_t [2:0]       freq_ref,
  output logic [2:0]                     freq_ok
);
  import rcf_pkg::*;
  // references sit 1 Hz apart so a wrong selection shows at once
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_ref <= '0;
      freq_ok  <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        freq_ref[k] <= f_cmd + 16'(k) * 16'h0064 - 16'h0064;
      end
      freq_ok <= {3{ok_cmd}};
    end
  end
endmodule : rcf_freq_src
`default_nettype wire

//--- verif/rcf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"
module rcf_top_tb;
  import rcf_pkg::*;
  localparam int          N_STAGES    = 2;
  localparam int          N_GROUPS    = 2;
  localparam int          STEP_CYCLES = 20;
  localparam rcf_status_t SN = RCF_ST_NORMAL;
  localparam rcf_status_t SS = RCF_ST_START;
  localparam rcf_status_t ST = RCF_ST_TRIP;
  localparam rcf_status_t SB = RCF_ST_BLOCKED;
  localparam rcf_slope_t  MAXR = rcf_slope_t'(`RCF_MAX_RATE_DEF);
  typedef struct packed {
    rcf_freq_t f; logic ok; rcf_slope_t sl; logic mb; rcf_status_t s0; rcf_status_t s1;
  } rcf_note_t;
  logic                                      clk, rst, func_active, force_allow, cnt_clr;
  logic                                      ok_cmd, max_blocked, step_out, okp;
  rcf_freq_t                                 f_cmd, freq_out, fp;
  rcf_freq_t [2:0]                           freq_ref;
  logic [2:0]                                freq_ok;
  logic [0:0]                                active_group;
  logic [1:0]                                block_in, ref_sel, rsel;
  rcf_grp_set_t [N_GROUPS-1:0][N_STAGES-1:0] grp_set;
  rcf_status_t [1:0]                         stage_status;
  rcf_events_t [1:0]                         stage_events;
  rcf_counts_t [1:0]                         stage_counts;
  logic [1:0][15:0]                          time_left;
  rcf_slope_t                                slope_out;
  rcf_note_t                                 q[$];
  int                                        fails, checks, seed, nstep;

  rcf_freq_src rcf_freq_src_i (.clk(clk), .rst(rst), .f_cmd(f_cmd), .ok_cmd(ok_cmd),
    .freq_ref(freq_ref), .freq_ok(freq_ok));
  rcf_top #(.N_STAGES(N_STAGES), .N_GROUPS(N_GROUPS), .STEP_CYCLES(STEP_CYCLES)) rcf_top_i (
    .clk(clk), .rst(rst), .freq_ref(freq_ref), .freq_ok(freq_ok), .ref_sel(ref_sel),
    .func_active(func_active), .max_rate(`RCF_MAX_RATE_DEF), .stage_en(2'h3),
    .force_allow(force_allow), .force_status({SB, ST}), .active_group(active_group),
    .grp_set(grp_set), .block_in(block_in), .cnt_clr(cnt_clr), .stage_status(stage_status),
    .stage_events(stage_events), .stage_counts(stage_counts), .time_left(time_left),
    .slope_out(slope_out), .freq_out(freq_out), .max_blocked(max_blocked), .step_out(step_out));

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %0t value %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // ctl bits: 0 ref good, 1 active, 2 forcing, 3 group, 5:4 block per stage
  task automatic st(input rcf_freq_t f, input logic [5:0] c, input rcf_status_t e0, e1);
    rcf_note_t n;
    int        k;
    if (!c[0]) f = rcf_freq_t'($random(seed));
    // offset the command so the selected reference always carries f
    case (rsel)
      2'h1:    f_cmd <= f;
      2'h2:    f_cmd <= f - 16'h0064;
      default: f_cmd <= f + 16'h0064;
    endcase
    ref_sel <= rsel;
    ok_cmd <= c[0];
    func_active <= c[1];
    force_allow <= c[2];
    active_group <= c[3];
    block_in <= c[5:4];
    n.f = f;
    n.ok = c[0];
    n.sl = (c[0] && okp) ? (rcf_slope_t'(f) - rcf_slope_t'(fp)) * 26'sh0C8 : '0;
    n.mb = (n.sl > MAXR) || (n.sl < -MAXR);
    n.s0 = e0;
    n.s1 = e1;
    q.push_back(n);
    fp = f;
    okp = c[0];
    k = 0;
    @(posedge clk);
    while (step_out !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
  endtask : st

  initial begin : watch
    rcf_note_t   n;
    rcf_status_t p0;
    p0 = SN;
    forever begin
      @(posedge clk);
      if (step_out === 1'b1 && q.size() == 0) begin
        fails++;
        $display("unexpected %0t step without note", $time);
      end else if (step_out === 1'b1) begin
        n = q.pop_front();
        chk(slope_out, n.sl);
        chk(max_blocked, n.mb);
        if (n.ok) chk(freq_out, n.f);
        repeat (2) @(posedge clk);
        chk(stage_status[0], n.s0);
        chk(stage_status[1], n.s1);
        chk(stage_events[0].trip_on, n.s0 == ST && p0 != ST);
        chk(stage_events[0].blk_on, n.s0 == SB && p0 != SB);
        chk(stage_events[0].start_on, n.s0 == SS && p0 != SS);
        chk(stage_events[0].blk_off, n.s0 != SB && p0 == SB);
        if (nstep == 2) chk(time_left[0], 32'h2);
        p0 = n.s0;
        nstep++;
        $display("test step %0d checked", nstep);
      end
    end
  end

  initial begin : watchdog
    #200000;
    fails++;
    $display("unexpected %0t run did not finish", $time);
    test_done();
  end

  initial begin : main
    clk = 1'b0;
    rst = 1'b1;
    seed = 32'h4BE00831;
    {func_active, force_allow, cnt_clr, ok_cmd, okp} = '0;
    {active_group, block_in, ref_sel, rsel, fp, f_cmd, fails, checks, nstep} = '0;
    grp_set = '0;
    grp_set[0][0] = '{1'h1, RCF_MODE_RISING, 1'h0, 16'h00CD, `RCF_F_UNDER_DEF, `RCF_F_OVER_DEF,
      16'h0003};
    grp_set[0][1] = '{1'h1, RCF_MODE_FALLING, 1'h1, 16'h00CD, `RCF_F_UNDER_DEF, `RCF_F_OVER_DEF,
      16'h0002};
    grp_set[1][0] = grp_set[0][0];
    grp_set[1][0].mode = RCF_MODE_BOTH;
    grp_set[1][0].limit_en = 1'h1;
    grp_set[1][0].f_over = 16'h13AF;
    grp_set[1][1] = grp_set[0][1];
    grp_set[1][1].used = 1'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    st(16'h1388, 6'h03, SN, SN);
    st(16'h1388, 6'h03, SN, SN);
    st(16'h138A, 6'h03, SS, SN);
    st(16'h138B, 6'h03, SS, SN);
    st(16'h138C, 6'h03, ST, SN);
    st(16'h138C, 6'h03, SN, SN);
    rsel = 2'h2;
    st(16'h138A, 6'h03, SN, SS);
    st(16'h1388, 6'h03, SN, SS);
    st(16'h1382, 6'h03, SN, ST);
    st(16'h1382, 6'h03, SN, SN);
    st(16'h1384, 6'h13, SB, SN);
    st(16'h1386, 6'h03, SS, SN);
    st(16'h1388, 6'h13, SB, SN);
    st(16'h138A, 6'h03, SS, SN);
    st(16'h138C, 6'h03, SS, SN);
    st(16'h138C, 6'h03, SN, SN);
    rsel = 2'h3;
    st(16'h1396, 6'h03, SS, SN);
    st(16'h13A1, 6'h03, SB, SN);
    st(16'h13A1, 6'h03, SN, SN);
    rsel = 2'h1;
    st(16'h139F, 6'h0B, SS, SN);
    st(16'h139F, 6'h0B, SN, SN);
    st(16'h0000, 6'h0A, SN, SN);
    st(16'h13A8, 6'h0B, SN, SN);
    st(16'h13AA, 6'h0B, SS, SN);
    st(16'h13AC, 6'h0B, SS, SN);
    st(16'h13AE, 6'h0B, SS, SN);
    st(16'h13B0, 6'h0B, ST, SN);
    st(16'h13AA, 6'h07, ST, SB);
    st(16'h13AA, 6'h03, SN, SN);
    st(16'h13AC, 6'h01, SN, SN);
    st(16'h13AE, 6'h03, SS, SN);
    st(16'h13AE, 6'h03, SN, SN);
    repeat (4) @(posedge clk);
    chk(stage_counts[0].blk_cnt, 32'h3);
    chk(stage_counts[0].trip_cnt, 32'h2);
    chk(stage_counts[0].start_cnt, 32'h7);
    chk(q.size(), 32'h0);
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(stage_counts[0].blk_cnt, 32'h0);
    test_done();
  end
endmodule : rcf_top_tb

bind rcf_top rcf_top_properties #(.N_STAGES(N_STAGES), .STEP_CYCLES(STEP_CYCLES))
  rcf_top_properties_i (.clk(clk), .rst(rst), .func_active(func_active), .max_rate(max_rate),
  .cnt_clr(cnt_clr), .stage_status(stage_status), .stage_events(stage_events),
  .stage_counts(stage_counts), .time_left(time_left), .slope_out(slope_out),
  .max_blocked(max_blocked), .step_out(step_out));
`default_nettype wire
